// ===== cses_defs.svh
// Purpose: Constants for the command structure byte/word swap block
// Assumes: Address buffer port control field holds the swap bits
// Notes:   Bit positions inside the control field are local choices
`ifndef CSES_DEFS_SVH
`define CSES_DEFS_SVH

// =====================================================================
// Control field bits
`define CSES_CTRL_W         8
`define CSES_CTRL_BYTE_SWAP 0
`define CSES_CTRL_WORD_SWAP 1

// =====================================================================
// Parameter block double-word offsets
`define CSES_PB_CMD_ID   8'h00
`define CSES_PB_FLAGS    8'h04
`define CSES_PB_ADDR     8'h08
`define CSES_PB_COUNT    8'h0c
`define CSES_DW_W        32

`endif

// ===== cses_pkg.sv
// Purpose: Types for the command structure byte/word swap block
// Assumes: cses_defs.svh provides widths
// Notes:   cses_dword_type carries a double-word with its kind marker
`include "cses_defs.svh"
package cses_pkg;

  // =====================================================================
  // Swap configuration
  typedef struct packed {
    logic word_swap;
    logic byte_swap;
  } cses_swap_type;

  // =====================================================================
  // One double-word in flight
  typedef struct packed {
    logic                    valid;
    logic                    is_struct;
    logic [`CSES_DW_W-1:0]   data;
  } cses_dword_type;

  // =====================================================================
  // Parameter block double-word 04H fields, big-endian view
  typedef struct packed {
    logic [7:0] flags2;
    logic [7:0] flags1;
    logic [7:0] addr_mod;
    logic [7:0] target_id;
  } cses_pb_flags_type;

endpackage

// ===== cses_swap.sv
// What this block does
// - With no swap bit set, structure double-words pass in big-endian order, MSB at lowest byte.
// - Byte swap and word swap are two independent controls usable alone or together.
// - Swap controls are latched from the control field of the first address buffer port word.
// - Swapping acts on whole 32-bit double-words regardless of the field sizes inside them.
// - Payload data passes unchanged whatever the swap settings are.
// - Parameter block: 00H id, 04H flags2/flags1/addr-mod/target, 08H address, 0CH count.
// - For a little-endian host the byte at offset 3 takes the place of big-endian offset 0.
// - Both swaps together give automatic full reordering for a little-endian host.
//
// Purpose: Converts command structure double-words between host and internal order
// Assumes: One clock; host side words already synchronous to clk
// Notes:   Same conversion serves fetch and return; it is its own inverse
`timescale 1ns/1ps
`include "cses_defs.svh"
module cses_swap (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  nrst,
  // Address buffer port word
  input  wire logic                  abp_wr,
  input  wire logic                  abp_first,
  input  wire logic [`CSES_CTRL_W-1:0] abp_ctrl,
  // Fetch from host memory
  input  wire cses_pkg::cses_dword_type fetch_in,
  output cses_pkg::cses_dword_type   fetch_out,
  // Return to host memory
  input  wire cses_pkg::cses_dword_type ret_in,
  output cses_pkg::cses_dword_type   ret_out,
  // Decoded parameter block view
  input  wire logic [7:0]            fetch_offset,
  output cses_pkg::cses_pb_flags_type pb_flags,
  output logic [`CSES_DW_W-1:0]      pb_cmd_id,
  output logic [`CSES_DW_W-1:0]      pb_host_addr,
  output logic [`CSES_DW_W-1:0]      pb_xfer_count,
  // Current configuration
  output cses_pkg::cses_swap_type    swap_cfg
);
  import cses_pkg::*;

  // =====================================================================
  // Next values and shared nets
  cses_swap_type         swap_cfg_nxt;
  cses_dword_type        fetch_out_nxt;
  cses_dword_type        ret_out_nxt;
  cses_pb_flags_type     pb_flags_nxt;
  logic [`CSES_DW_W-1:0] pb_cmd_id_nxt;
  logic [`CSES_DW_W-1:0] pb_host_addr_nxt;
  logic [`CSES_DW_W-1:0] pb_xfer_count_nxt;
  logic [`CSES_DW_W-1:0] fetch_conv;
  logic                  cfg_load;
  logic                  pb_word;

  // =====================================================================
  // Single swap steps
  function automatic logic [`CSES_DW_W-1:0] swap_bytes(input logic [`CSES_DW_W-1:0] d);
    logic [`CSES_DW_W-1:0] t;
    t = {d[23:16], d[31:24], d[7:0], d[15:8]};
    return t;
  endfunction

  function automatic logic [`CSES_DW_W-1:0] swap_halves(input logic [`CSES_DW_W-1:0] d);
    logic [`CSES_DW_W-1:0] t;
    t = {d[15:0], d[31:16]};
    return t;
  endfunction

  // =====================================================================
  // Parameter block slot decode
  function automatic logic pb_slot(input logic [7:0] offs, input logic [7:0] slot);
    logic hit;
    hit = (offs == slot);
    return hit;
  endfunction

  // =====================================================================
  // Conversion function
  function automatic logic [`CSES_DW_W-1:0] conv(input logic [`CSES_DW_W-1:0] d,
                                                  input cses_swap_type s);
    logic [`CSES_DW_W-1:0] t;
    t = d;
    if (s.byte_swap) begin
      t = swap_bytes(t);
    end
    if (s.word_swap) begin
      t = swap_halves(t);
    end
    return t;
  endfunction

  function automatic cses_dword_type pass(input cses_dword_type w, input cses_swap_type s);
    cses_dword_type o;
    o = w;
    if (w.is_struct) begin
      o.data = conv(w.data, s);
    end
    return o;
  endfunction

  // =====================================================================
  // Swap configuration capture
  // first word only
  assign cfg_load = abp_wr && abp_first;

  always_comb begin
    swap_cfg_nxt = swap_cfg;
    if (cfg_load) begin
      swap_cfg_nxt.byte_swap = abp_ctrl[`CSES_CTRL_BYTE_SWAP];
      swap_cfg_nxt.word_swap = abp_ctrl[`CSES_CTRL_WORD_SWAP];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      swap_cfg <= '0;
    end else begin
      swap_cfg <= swap_cfg_nxt;
    end
  end

  // =====================================================================
  // Fetch path
  // no bits, no change
  always_comb begin
    fetch_out_nxt = pass(fetch_in, swap_cfg);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fetch_out <= '0;
    end else begin
      fetch_out <= fetch_out_nxt;
    end
  end

  // =====================================================================
  // Return path
  // same per-word rule
  always_comb begin
    ret_out_nxt = pass(ret_in, swap_cfg);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ret_out <= '0;
    end else begin
      ret_out <= ret_out_nxt;
    end
  end

  // =====================================================================
  // Parameter block next values
  // structure words only
  assign pb_word    = fetch_in.valid && fetch_in.is_struct;
  assign fetch_conv = conv(fetch_in.data, swap_cfg);

  always_comb begin
    pb_cmd_id_nxt     = pb_cmd_id;
    pb_flags_nxt      = pb_flags;
    pb_host_addr_nxt  = pb_host_addr;
    pb_xfer_count_nxt = pb_xfer_count;
    if (pb_word && pb_slot(fetch_offset, `CSES_PB_CMD_ID)) begin
      pb_cmd_id_nxt = fetch_conv;
    end
    if (pb_word && pb_slot(fetch_offset, `CSES_PB_FLAGS)) begin
      pb_flags_nxt = cses_pb_flags_type'(fetch_conv);
    end
    if (pb_word && pb_slot(fetch_offset, `CSES_PB_ADDR)) begin
      pb_host_addr_nxt = fetch_conv;
    end
    if (pb_word && pb_slot(fetch_offset, `CSES_PB_COUNT)) begin
      pb_xfer_count_nxt = fetch_conv;
    end
  end

  // =====================================================================
  // Parameter block registers
  // command identifier
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pb_cmd_id <= '0;
    end else begin
      pb_cmd_id <= pb_cmd_id_nxt;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pb_flags <= '0;
    end else begin
      pb_flags <= pb_flags_nxt;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pb_host_addr <= '0;
    end else begin
      pb_host_addr <= pb_host_addr_nxt;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pb_xfer_count <= '0;
    end else begin
      pb_xfer_count <= pb_xfer_count_nxt;
    end
  end

endmodule

// ===== cses_monitor.sv
// Purpose: Port assertions for the swap block
// Assumes: Swap bits load on first port word
// Notes:   Conversion compares with last cycle inputs
`timescale 1ns/1ps
module cses_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Port word
  input wire logic abp_wr,
  input wire logic abp_first,
  input wire logic [7:0] abp_ctrl,
  // Paths
  input wire cses_pkg::cses_dword_type fetch_in,
  input wire cses_pkg::cses_dword_type fetch_out,
  input wire cses_pkg::cses_dword_type ret_in,
  input wire cses_pkg::cses_dword_type ret_out,
  input wire cses_pkg::cses_swap_type swap_cfg
);
  import cses_pkg::*;

  // =====================================================================
  // Clocking and reference conversion
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  function automatic logic [31:0] cv(input logic [31:0] d, input logic [1:0] s);
    logic [31:0] t;
    t = d;
    if (s[0]) t = {t[23:16], t[31:24], t[7:0], t[15:8]};
    if (s[1]) t = {t[15:0], t[31:16]};
    return t;
  endfunction

  // =====================================================================
  // Assertions
  sequence s_cfg_wr;
    abp_wr && abp_first;
  endsequence
  AST_CFG_LOAD: assert property (s_cfg_wr |=> swap_cfg == $past(abp_ctrl[1:0]))
    else $error("swap bits not loaded");
  AST_CFG_HOLD: assert property (!(abp_wr && abp_first) |=> $stable(swap_cfg))
    else $error("swap bits changed");
  AST_F_CONV: assert property (fetch_in.is_struct |=>
    fetch_out.data == cv($past(fetch_in.data), $past(swap_cfg))) else $error("fetch conv");
  AST_F_NONE: assert property (fetch_in.is_struct && swap_cfg == 2'h0 |=>
    fetch_out.data == $past(fetch_in.data)) else $error("fetch order");
  AST_F_PAY: assert property (!fetch_in.is_struct |=>
    fetch_out.data == $past(fetch_in.data)) else $error("fetch payload");
  AST_R_CONV: assert property (ret_in.is_struct |=>
    ret_out.data == cv($past(ret_in.data), $past(swap_cfg))) else $error("return conv");
  AST_R_PAY: assert property (!ret_in.is_struct |=>
    ret_out.data == $past(ret_in.data)) else $error("return payload");
  AST_R_KIND: assert property (1 |=> ret_out.is_struct == $past(ret_in.is_struct))
    else $error("return kind");
endmodule

// ===== cses_host_mem.sv
// Purpose: Host memory holding one parameter block
// Assumes: A read answers at the next edge
// Notes:   Idle bus shows the inverted last word
`timescale 1ns/1ps
module cses_host_mem (
  // Clock and request
  input wire logic clk,
  input wire logic rd,
  input wire logic le,
  input wire logic pay,
  input wire logic [1:0] idx,
  // Answer
  output cses_pkg::cses_dword_type word,
  output logic [7:0] offs
);
  import cses_pkg::*;
  logic [31:0] be [4] = '{32'h04030201, 32'h01863e02, 32'h005a9320, 32'h00010280};
  initial word = '0;
  initial offs = '0;
  function automatic logic [31:0] rev(input logic [31:0] d);
    logic [31:0] t;
    t = {d[7:0], d[15:8], d[23:16], d[31:24]};
    return t;
  endfunction
  always @(posedge clk) begin
    offs <= {4'h0, idx, 2'h0};
    if (rd) word <= {1'b1, !pay, le ? rev(be[idx]) : be[idx]};
    else word <= {2'b00, ~word.data};
  end
endmodule

// ===== tb_command_structure_endian_swap.sv
// Purpose: Self-checking bench for the swap block
// Assumes: Host model feeds the fetch path
// Notes:   Expected words worked out by hand
`timescale 1ns/1ps
module tb_command_structure_endian_swap;
  import cses_pkg::*;
  logic clk = 0, nrst = 0, abp_wr = 0, abp_first = 0, rd = 0, le = 0, pay = 0;
  logic [7:0] abp_ctrl = '0, offs;
  logic [1:0] idx = '0;
  cses_dword_type fin, fout, rin = '0, rout;
  cses_pb_flags_type flg;
  logic [31:0] cid, hadr, cnt;
  cses_swap_type cfg_o;
  int mismatches = 0, checks_done = 0, cycles = 0;
  logic [31:0] mx [4] = '{32'h11223344, 32'h22114433, 32'h33441122, 32'h44332211};
  always #12.5 clk = ~clk;
  cses_host_mem HOST (.clk(clk), .rd(rd), .le(le), .pay(pay), .idx(idx), .word(fin), .offs(offs));
  cses_swap DUT (.clk(clk), .nrst(nrst), .abp_wr(abp_wr), .abp_first(abp_first),
    .abp_ctrl(abp_ctrl), .fetch_in(fin), .fetch_out(fout), .ret_in(rin), .ret_out(rout),
    .fetch_offset(offs), .pb_flags(flg), .pb_cmd_id(cid), .pb_host_addr(hadr),
    .pb_xfer_count(cnt), .swap_cfg(cfg_o));
  task automatic chk(input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic print_verdict;
    if (mismatches == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // =====================================================================
  // Scenarios
  task automatic cfg(input logic f, input logic [7:0] c, input logic [1:0] e);
    @(posedge clk);
    abp_wr <= 1'h1;
    abp_first <= f;
    abp_ctrl <= c;
    @(posedge clk);
    abp_wr <= 1'h0;
    #1;
    chk({30'h0, cfg_o}, {30'h0, e});
  endtask
  task automatic t_cfg;
    cfg(1'h0, 8'h03, 2'h0);
    cfg(1'h1, 8'h02, 2'h2);
    cfg(1'h0, 8'h01, 2'h2);
  endtask
  task automatic t_modes;
    for (int c = 0; c < 4; c++) begin
      cfg(1'h1, c[7:0], c[1:0]);
      @(posedge clk);
      rin <= {2'h3, 32'h11223344};
      @(posedge clk);
      rin <= {2'h2, 32'h11223344};
      #1;
      chk(rout.data, mx[c]);
      @(posedge clk);
      #1;
      chk(rout.data, 32'h11223344);
    end
  endtask
  task automatic t_block(input logic l, p, input logic [7:0] c);
    cfg(1'h1, c, c[1:0]);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      rd <= 1'h1;
      idx <= i[1:0];
      le <= l;
      pay <= p;
    end
    @(posedge clk);
    rd <= 1'h0;
    @(posedge clk);
    #1;
    chk(fout.data, p ? 32'h80020100 : 32'h00010280);
    if (!p) begin
      chk(cid, 32'h04030201);
      chk(flg, 32'h01863e02);
      chk(hadr, 32'h005a9320);
      chk(cnt, 32'h00010280);
    end
  endtask
  task automatic t_reset;
    @(posedge clk);
    nrst <= 1'h0;
    #1;
    chk(cid, 32'h0);
    chk({30'h0, cfg_o}, 32'h0);
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
  endtask

  // =====================================================================
  // Timeout and run order
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      mismatches++;
      print_verdict;
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'h1;
    t_cfg;
    t_modes;
    t_block(1'h1, 1'h0, 8'h03);
    t_reset;
    t_block(1'h0, 1'h0, 8'h00);
    t_block(1'h1, 1'h1, 8'h03);
    print_verdict;
  end
endmodule
bind cses_swap cses_monitor MON (.clk(clk), .nrst(nrst), .abp_wr(abp_wr),
  .abp_first(abp_first), .abp_ctrl(abp_ctrl), .fetch_in(fetch_in), .fetch_out(fetch_out),
  .ret_in(ret_in), .ret_out(ret_out), .swap_cfg(swap_cfg));
